// *** hw/adc_serial_pkg.sv ***
package adc_serial_pkg;

  // ---------------------------------------------------------------
  // widths, buffer depth and field positions of the configuration word
  // ---------------------------------------------------------------
  localparam int          CFG_W      = 7;
  localparam int          RES_W      = 12;
  localparam int          CH_W       = 3;
  localparam int          CNT_W      = 5;
  localparam int          BUF_DEPTH  = 2;
  localparam int          POS_MODE   = 6;
  localparam int          POS_ODD    = 5;
  localparam int          POS_SEL_HI = 4;
  localparam int          POS_SEL_LO = 3;
  localparam int          POS_UNI    = 2;
  localparam int          POS_ORDER  = 1;
  localparam int          POS_SHDN   = 0;

  // ---------------------------------------------------------------
  // bit counts of the serial sequence and the no-channel pair value
  // ---------------------------------------------------------------
  localparam logic [4:0]  CFG_LAST   = 5'h06;
  localparam logic [4:0]  MSB_END    = 5'h0c;
  localparam logic [4:0]  LSB_END    = 5'h17;
  localparam logic [4:0]  SEQ_END    = 5'h18;
  localparam logic [1:0]  SEL_NONE   = 2'h3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [6:0]  CFG_RST    = 7'h00;
  localparam logic [11:0] RES_RST    = 12'h000;
  localparam logic [4:0]  CNT_RST    = 5'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HUNT,
    ST_CFG,
    ST_NULL,
    ST_DATA
  } link_state_t;

  typedef struct packed {
    logic [CH_W-1:0] pos_ch;
    logic [CH_W-1:0] neg_ch;
    logic            neg_is_common;
    logic            valid;
  } mux_sel_t;

endpackage : adc_serial_pkg

// *** hw/result_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none

module result_buffer #(
  parameter int W = adc_serial_pkg::RES_W
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic [1:0]   count;
    logic         ready;
  } buf_state_t;

  buf_state_t state_reg;
  buf_state_t state_next;
  logic       push;
  logic       pop;

  assign in_ready  = state_reg.ready;
  assign out_valid = (state_reg.count != 2'h0);
  assign out_data  = state_reg.head;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    state_next = state_reg;
    if (pop) begin
      state_next.head = state_reg.tail;
    end
    unique case ({push, pop})
      2'b10: begin
        if (state_reg.count == 2'h0) begin
          state_next.head = in_data;
        end else begin
          state_next.tail = in_data;
        end
        state_next.count = state_reg.count + 2'h1;
      end
      2'b01: begin
        state_next.count = state_reg.count - 2'h1;
      end
      2'b11: begin
        // one in, one out: the survivor becomes the head
        if (state_reg.count == 2'h1) begin
          state_next.head = in_data;
        end else begin
          state_next.tail = in_data;
        end
      end
      2'b00: begin
      end
    endcase
    if (flush) begin
      state_next.count = 2'h0;
    end
    // kept in a flop so the converter side never sees a compare output
    state_next.ready = (state_next.count != 2'(adc_serial_pkg::BUF_DEPTH));
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg       <= '0;
      state_reg.ready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : result_buffer

`default_nettype wire

// *** hw/adc_serial_ctrl.sv ***
// Functional notes
// [RULE1] launch bits on falling serial clock, sample on rising edge.
// [RULE2] configuration is received completely before any result goes out.
// [RULE3] data output idles released so input and output may share a wire.
// [RULE4] select falling starts a transaction and a start-bit search.
// [RULE5] zeros before the first sampled one are discarded; the one is start.
// [RULE6] seven configuration bits follow the start bit on rising edges.
// [RULE7] after the word, one null bit, then the result shifts out.
// [RULE8] result sent belongs to this transaction's own conversion.
// [RULE9] select rising resets the interface for the next transaction.
// [RULE10] after the word, input activity is ignored until a new select cycle.
// [RULE11] first four bits: input mode, polarity, pair high, pair low.
// [RULE12] mode 0 differential on pair 2n/2n+1; polarity picks positive channel.
// [RULE13] mode 1 single ended: channel 2n plus polarity against common.
// [RULE14] unipolar bit one unipolar, zero bipolar with sign.
// [RULE15] order bit one: msb first then zeros; zero: lsb-first copy follows.
// [RULE16] shutdown bit zero: shut down, send twelve ones then zeros.
// [RULE17] shutdown output low from shutdown until next select cycle.
// [RULE18] last three bits: unipolar, bit order, shutdown.
// [RULE19] result is twelve bits; output released while idle or receiving.
// [RULE20] six-channel variant: pair value 11 selects no channel.
`timescale 1ns/1ps
`default_nettype none

module adc_serial_ctrl (
  input  wire logic                              clk_sys,
  input  wire logic                              nrst,
  input  wire logic                              cs_n_pin,
  input  wire logic                              sclk_pin,
  input  wire logic                              din_pin,
  input  wire logic                              six_ch_variant,
  output logic                                   dout,
  output logic                                   dout_oe_n,
  output logic                                   sys_shutdown_n,
  output logic                                   conv_start,
  output adc_serial_pkg::mux_sel_t               mux_sel,
  output logic                                   unipolar_mode,
  input  wire logic                              res_valid,
  output logic                                   res_ready,
  input  wire logic [adc_serial_pkg::RES_W-1:0]  res_data
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                        cs_sync;
    logic [1:0]                        sclk_sync;
    logic [1:0]                        din_sync;
    logic                              sclk_prev;
    logic                              cs_prev;
    adc_serial_pkg::link_state_t       st;
    logic [adc_serial_pkg::CNT_W-1:0]  cnt;
    logic [adc_serial_pkg::CFG_W-1:0]  cfg;
    logic [adc_serial_pkg::RES_W-1:0]  result;
    logic                              have_result;
    logic                              shutdown;
    logic                              dout;
    logic                              dout_oe_n;
    logic                              sso_n;
    logic                              conv_start;
    adc_serial_pkg::mux_sel_t          mux;
    logic                              unipolar_bit;
  } ctrl_state_t;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;

  logic                             buf_valid;
  logic                             buf_pop;
  logic [adc_serial_pkg::RES_W-1:0] buf_data;
  logic                             sclk_rise;
  logic                             sclk_fall;
  logic                             cs_s;
  logic                             din_s;
  logic [adc_serial_pkg::CFG_W-1:0] cfg_new;

  // ---------------------------------------------------------------
  // result path: two-entry buffer between converter and shifter
  // ---------------------------------------------------------------
  // flushed while select is high so a late word never leaks into
  // the next transaction
  result_buffer #(
    .W (adc_serial_pkg::RES_W)
  ) u_result_buffer (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .flush     (cs_s),                                            // RULE8
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .in_data   (res_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  assign cs_s      = state_reg.cs_sync[1];
  assign din_s     = state_reg.din_sync[1];
  assign sclk_rise = state_reg.sclk_sync[1] && !state_reg.sclk_prev;
  assign sclk_fall = !state_reg.sclk_sync[1] && state_reg.sclk_prev;
  assign buf_pop   = (state_reg.st == adc_serial_pkg::ST_NULL)
                     && !state_reg.have_result && !state_reg.shutdown;
  assign cfg_new   = {state_reg.cfg[adc_serial_pkg::CFG_W-2:0], din_s};

  // ---------------------------------------------------------------
  // output bit sequence by position
  // ---------------------------------------------------------------
  function automatic logic seq_bit(
    input logic [adc_serial_pkg::RES_W-1:0] res,
    input logic [adc_serial_pkg::CNT_W-1:0] idx,
    input logic                             bit_order_bit,
    input logic                             unipolar_bit,
    input logic                             shdn
  );
    logic b;
    b = 1'b0;
    if (shdn) begin
      b = (idx < adc_serial_pkg::MSB_END);                        // RULE16
    end else if (idx < adc_serial_pkg::MSB_END) begin
      b = res[4'(adc_serial_pkg::MSB_END - 5'h01 - idx)];         // RULE15
    end else if (!bit_order_bit && idx < adc_serial_pkg::LSB_END) begin
      // lsb-first copy shares the lsb already sent
      b = res[4'(idx - adc_serial_pkg::MSB_END + 5'h01)];         // RULE15
    end else if (!bit_order_bit && !unipolar_bit && idx == adc_serial_pkg::LSB_END) begin
      b = res[adc_serial_pkg::RES_W-1];                           // RULE14
    end
    return b;
  endfunction : seq_bit

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next            = state_reg;
    state_next.cs_sync    = {state_reg.cs_sync[0], cs_n_pin};
    state_next.sclk_sync  = {state_reg.sclk_sync[0], sclk_pin};
    state_next.din_sync   = {state_reg.din_sync[0], din_pin};
    state_next.sclk_prev  = state_reg.sclk_sync[1];
    state_next.cs_prev    = cs_s;
    state_next.conv_start = 1'b0;

    if (buf_pop && buf_valid) begin
      state_next.result      = buf_data;                          // RULE8
      state_next.have_result = 1'b1;
    end

    unique case (state_reg.st)
      adc_serial_pkg::ST_IDLE: begin
        if (state_reg.cs_prev && !cs_s) begin
          state_next.st    = adc_serial_pkg::ST_HUNT;             // RULE4
          state_next.sso_n = 1'b1;                                // RULE17
        end
      end
      adc_serial_pkg::ST_HUNT: begin
        if (sclk_rise && din_s) begin
          state_next.st  = adc_serial_pkg::ST_CFG;                // RULE5
          state_next.cnt = adc_serial_pkg::CNT_RST;
        end
      end
      adc_serial_pkg::ST_CFG: begin
        if (sclk_rise) begin
          state_next.cfg = cfg_new;                               // RULE6
          state_next.cnt = state_reg.cnt + 5'h01;
          if (state_reg.cnt == adc_serial_pkg::CFG_LAST) begin
            // word complete: further input is never looked at
            state_next.st       = adc_serial_pkg::ST_NULL;        // RULE10
            state_next.unipolar_bit      = cfg_new[adc_serial_pkg::POS_UNI]; // RULE18
            state_next.shutdown = !cfg_new[adc_serial_pkg::POS_SHDN];
            state_next.sso_n    = cfg_new[adc_serial_pkg::POS_SHDN]; // RULE17
            state_next.conv_start = cfg_new[adc_serial_pkg::POS_SHDN];
            state_next.mux.pos_ch = {cfg_new[adc_serial_pkg::POS_SEL_HI],
                                     cfg_new[adc_serial_pkg::POS_SEL_LO],
                                     cfg_new[adc_serial_pkg::POS_ODD]}; // RULE11 RULE13
            state_next.mux.neg_ch = {cfg_new[adc_serial_pkg::POS_SEL_HI],
                                     cfg_new[adc_serial_pkg::POS_SEL_LO],
                                     !cfg_new[adc_serial_pkg::POS_ODD]}; // RULE12
            state_next.mux.neg_is_common = cfg_new[adc_serial_pkg::POS_MODE]; // RULE13
            state_next.mux.valid = !(six_ch_variant
              && cfg_new[adc_serial_pkg::POS_SEL_HI:adc_serial_pkg::POS_SEL_LO]
                 == adc_serial_pkg::SEL_NONE);                    // RULE20
          end
        end
      end
      adc_serial_pkg::ST_NULL: begin
        if (sclk_fall) begin
          state_next.dout      = 1'b0;                            // RULE7 RULE1
          state_next.dout_oe_n = 1'b0;                            // RULE2
          state_next.st        = adc_serial_pkg::ST_DATA;
          state_next.cnt       = adc_serial_pkg::CNT_RST;
        end
      end
      adc_serial_pkg::ST_DATA: begin
        if (sclk_fall) begin
          state_next.dout = seq_bit(state_reg.result, state_reg.cnt,
                                    state_reg.cfg[adc_serial_pkg::POS_ORDER],
                                    state_reg.unipolar_bit, state_reg.shutdown); // RULE1
          // saturate so zeros fill for as long as clocking continues
          if (state_reg.cnt != adc_serial_pkg::SEQ_END) begin
            state_next.cnt = state_reg.cnt + 5'h01;
          end
        end
      end
    endcase

    // select high wins over the sequencer state, word and result and releases the data wire
    if (cs_s) begin
      state_next.st          = adc_serial_pkg::ST_IDLE;           // RULE9
      state_next.cnt         = adc_serial_pkg::CNT_RST;
      state_next.cfg         = adc_serial_pkg::CFG_RST;
      state_next.have_result = 1'b0;
      state_next.result      = adc_serial_pkg::RES_RST;
      state_next.dout        = 1'b0;
      state_next.dout_oe_n   = 1'b1;                              // RULE19 RULE3
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg           <= '0;
      state_reg.cs_sync   <= 2'h3;
      state_reg.cs_prev   <= 1'b1;
      state_reg.st        <= adc_serial_pkg::ST_IDLE;
      state_reg.dout_oe_n <= 1'b1;
      state_reg.sso_n     <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dout           = state_reg.dout;
  assign dout_oe_n      = state_reg.dout_oe_n;
  assign sys_shutdown_n = state_reg.sso_n;
  assign conv_start     = state_reg.conv_start;
  assign mux_sel        = state_reg.mux;
  assign unipolar_mode  = state_reg.unipolar_bit;

endmodule : adc_serial_ctrl

`default_nettype wire

// *** tb/adc_serial_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

module adc_serial_asserts (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic sys_shutdown_n,
  input wire logic conv_start,
  input wire logic res_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // select idle long enough to clear the synchronisers
  // ----------------------------------------
  sequence s_cs_idle;
    cs_n_pin [*6];
  endsequence
  sequence s_quiet;
    !conv_start [*8];
  endsequence

  a_oe_idle: assert property (s_cs_idle |-> dout_oe_n)
    else $error("output driven while deselected");
  a_idle_start: assert property (s_cs_idle |-> !conv_start)
    else $error("conversion started while deselected");
  a_flush_ready: assert property (s_cs_idle |-> res_ready)
    else $error("buffer not flushed while deselected");
  a_start_once: assert property (conv_start |=> s_quiet)
    else $error("second conversion in one transaction");
  a_rx_release: assert property (conv_start |-> dout_oe_n)
    else $error("output driven before the word was taken");
  a_start_live: assert property (conv_start |-> sys_shutdown_n)
    else $error("conversion started in shutdown");
  a_shdn_hold: assert property (!sys_shutdown_n && cs_n_pin |=> !sys_shutdown_n)
    else $error("shutdown output left early");
  a_shdn_wake: assert property ($rose(sys_shutdown_n) |-> !cs_n_pin)
    else $error("shutdown output released without select");
  a_oe_null: assert property ($fell(dout_oe_n) |-> !sclk_pin && !cs_n_pin && !dout)
    else $error("null bit wrong");
  a_dout_fall: assert property ($changed(dout) && !dout_oe_n |-> !sclk_pin)
    else $error("data changed outside clock low phase");
endmodule : adc_serial_asserts

bind adc_serial_ctrl adc_serial_asserts u_chk (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .cs_n_pin(cs_n_pin),
  .sclk_pin(sclk_pin),
  .dout(dout),
  .dout_oe_n(dout_oe_n),
  .sys_shutdown_n(sys_shutdown_n),
  .conv_start(conv_start),
  .res_ready(res_ready)
);

`default_nettype wire

// *** tb/host_port_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module host_port_model (
  input  wire logic clk_sys,
  input  wire logic line,
  output logic      cs_n = 1'b1,
  output logic      sclk = 1'b0,
  output logic      d    = 1'b0
);
  // half period kept above the 4-cycle floor the synchronisers need
  localparam int HALF = 6;

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_n

  task automatic bit_io(input logic b, output logic s);
    sclk <= 1'b0;
    d    <= b;
    wait_n(HALF);
    sclk <= 1'b1;
    s = line;
    wait_n(HALF);
  endtask : bit_io

  // after the word the host keeps toggling data, which the device must ignore
  task automatic xfer(input logic [6:0] cfg, input int nz, input int n,
                      output logic [47:0] got);
    logic s;
    got = '0;
    cs_n <= 1'b0;
    wait_n(HALF);
    for (int i = 0; i < nz; i++) bit_io(1'b0, s);
    bit_io(1'b1, s);
    for (int i = 6; i >= 0; i--) bit_io(cfg[i], s);
    for (int i = 0; i < n; i++) begin
      bit_io(i[0], s);
      got[i] = s;
    end
    sclk <= 1'b0;
    wait_n(HALF);
    cs_n <= 1'b1;
    wait_n(2 * HALF);
  endtask : xfer
endmodule : host_port_model

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                     clk_sys = 1'b0;
  logic                     nrst    = 1'b0;
  logic                     six_ch  = 1'b0;
  logic                     res_valid = 1'b0;
  logic                     kick    = 1'b0;
  logic                     saw_full = 1'b0;
  logic [11:0]              res_data = 12'h000;
  logic [11:0]              res_word = 12'h000;
  logic                     cs_n, sclk, host_d, dout, dout_oe_n;
  logic                     sys_shutdown_n, conv_start, res_ready, unipolar_mode;
  adc_serial_pkg::mux_sel_t mux_sel;
  int                       mismatches, n_checks, cyc, starts, left;
  int                       burst = 1;
  // shared data wire: device drives only while its enable is low
  wire logic                line = dout_oe_n ? host_d : dout;

  always #4 clk_sys = ~clk_sys;

  adc_serial_ctrl i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .cs_n_pin(cs_n), .sclk_pin(sclk), .din_pin(line),
    .six_ch_variant(six_ch), .dout(dout), .dout_oe_n(dout_oe_n),
    .sys_shutdown_n(sys_shutdown_n), .conv_start(conv_start), .mux_sel(mux_sel),
    .unipolar_mode(unipolar_mode), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data)
  );
  host_port_model i_host (
    .clk_sys(clk_sys), .line(line), .cs_n(cs_n), .sclk(sclk), .d(host_d)
  );

  // ----------------------------------------
  // converter: burst words after each start, held while the buffer refuses
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!res_ready) saw_full = 1'b1;
    if (conv_start) starts++;
    if (conv_start || kick) begin
      res_valid <= 1'b1;
      res_data  <= res_word;
      left      <= burst - 1;
    end else if (res_valid && res_ready) begin
      if (left == 0) res_valid <= 1'b0;
      else begin
        left     <= left - 1;
        res_data <= res_data + 12'h001;
      end
    end
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input logic [47:0] exp, input logic [47:0] got, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [47:0] exp_bits(input logic [6:0] c, input logic [11:0] r,
                                          input int n);
    logic [47:0] e;
    int          j;
    e = '0;
    for (int k = 1; k < n; k++) begin
      j = k - 1;
      if (!c[0]) e[k] = (j < 12);
      else if (j < 12) e[k] = r[11 - j];
      else if (!c[1] && j < 23) e[k] = r[j - 11];
      else if (!c[1] && !c[2] && j == 23) e[k] = r[11];
    end
    return e;
  endfunction : exp_bits

  task automatic t_mux();
    logic [47:0] g;
    for (int v = 0; v < 2; v++) begin
      six_ch <= v[0];
      for (int m = 0; m < 16; m++) begin
        i_host.xfer({m[3:0], m[0], 2'b11}, 0, 2, g);
        chk({m[1:0], m[2]}, mux_sel.pos_ch, "positive channel");
        if (!m[3]) chk({m[1:0], ~m[2]}, mux_sel.neg_ch, "negative channel");
        chk(m[3], mux_sel.neg_is_common, "common reference");
        chk(!(v[0] && m[1:0] == 2'h3), mux_sel.valid, "channel valid");
        chk(m[0], unipolar_mode, "unipolar mode");
      end
    end
    six_ch <= 1'b0;
  endtask : t_mux

  task automatic t_stream();
    logic [47:0] g;
    res_word = 12'hb4d;
    for (int m = 0; m < 4; m++) begin
      i_host.xfer({4'h9, m[1:0], 1'b1}, 3, 30, g);
      chk(exp_bits({4'h9, m[1:0], 1'b1}, 12'hb4d, 30), g, "result stream");
    end
  endtask : t_stream

  task automatic t_shdn();
    logic [47:0] g;
    int          s0;
    s0 = starts;
    i_host.xfer(7'h26, 0, 20, g);
    chk(exp_bits(7'h26, res_word, 20), g, "shutdown word");
    chk(0, starts - s0, "start in shutdown");
    chk(1'b0, sys_shutdown_n, "shutdown output");
    i_host.xfer(7'h27, 0, 2, g);
    chk(1'b1, sys_shutdown_n, "shutdown release");
  endtask : t_shdn

  task automatic t_stale();
    logic [47:0] g;
    int          s0;
    res_word = 12'h0f0;
    kick <= 1'b1;
    @(posedge clk_sys);
    kick <= 1'b0;
    repeat (4) @(posedge clk_sys);
    res_word = 12'h5a6;
    s0       = starts;
    i_host.xfer(7'h07, 0, 14, g);
    chk(exp_bits(7'h07, 12'h5a6, 14), g, "own conversion");
    chk(1, starts - s0, "one start per transaction");
  endtask : t_stale

  task automatic t_fill();
    logic [47:0] g;
    saw_full = 1'b0;
    burst    = 4;
    res_word = 12'h3c1;
    i_host.xfer(7'h07, 0, 14, g);
    chk(exp_bits(7'h07, 12'h3c1, 14), g, "first of burst");
    chk(1'b1, saw_full, "buffer refused");
    chk(1'b1, res_ready, "buffer flushed");
    burst = 1;
  endtask : t_fill

  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_mux();
    t_stream();
    t_shdn();
    t_stale();
    t_fill();
    conclude();
  end
endmodule : tb_top

`default_nettype wire
